// ---- verilog/gpio_pkg.sv ----
`default_nettype none
package gpio_pkg;
  // Register port widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // Register offsets
  localparam logic [7:0] PIN_CFG_ADDR    = 8'h24;
  localparam logic [7:0] MODE_CFG_ADDR   = 8'h25;
  localparam logic [7:0] PIN_STATUS_ADDR = 8'h30;

  // Reset values and writable bits
  localparam logic [15:0] PIN_CFG_RESET  = 16'h0000;
  localparam logic [15:0] MODE_CFG_RESET = 16'h0000;
  localparam logic [15:0] PIN_CFG_MASK   = 16'hbfff;

  // Pin configuration fields
  localparam int FILT_EN_BIT = 15;
  localparam int OUT_EN_BIT  = 13;
  localparam int OUT_SEL_LSB = 9;
  localparam int CH_SEL_LSB  = 5;
  localparam int CH1_SEL_BIT = 0;
  localparam int CH0_SEL_BIT = 3;
  localparam int IN_FUNC_LSB = 1;
  localparam int IN_EN_BIT   = 0;

  // Device mode fields
  localparam int LOW_POWER_BIT = 13;
  localparam int PROT_ACT_LSB  = 8;

  // Status register bits
  localparam int ST_RAW_BIT   = 0;
  localparam int ST_LEVEL_BIT = 1;
  localparam int ST_RESET_BIT = 2;
  localparam int ST_NVM_BIT   = 3;
  localparam int ST_LOCK_BIT  = 4;
  localparam int ST_CLEAR_BIT = 5;

  // Output status selection codes
  localparam logic [3:0] SEL_MEM_BUSY = 4'h1;
  localparam logic [3:0] SEL_CH1_BUSY = 4'h4;
  localparam logic [3:0] SEL_CH0_BUSY = 4'h7;
  localparam logic [3:0] SEL_CH1_WIN  = 4'h8;
  localparam logic [3:0] SEL_CH0_WIN  = 4'hb;

  // Input function codes
  localparam logic [3:0] FN_FAULT_DUMP = 4'h2;
  localparam logic [3:0] FN_CUR_PWR    = 4'h3;
  localparam logic [3:0] FN_VOLT_PWR   = 4'h4;
  localparam logic [3:0] FN_PROTECT    = 4'h5;
  localparam logic [3:0] FN_CLEAR      = 4'h7;
  localparam logic [3:0] FN_LOAD       = 4'h8;
  localparam logic [3:0] FN_WAVE       = 4'h9;
  localparam logic [3:0] FN_MARGIN     = 4'ha;
  localparam logic [3:0] FN_RESET      = 4'hb;
  localparam logic [3:0] FN_NVM_WP     = 4'hc;
  localparam logic [3:0] FN_REG_LOCK   = 4'hd;

  // Glitch filter timing
  localparam int CLK_PERIOD_NS     = 50;
  localparam int FILTER_TIME_NS    = 150;
  localparam int FILTER_CYCLES_DEF = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// ---- verilog/pin_conditioner.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_conditioner
  import gpio_pkg::*;
#(
  parameter int FILTER_CYCLES = FILTER_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Pin and mode
  input  wire logic pin_in,
  input  wire logic filter_en,
  // Conditioned level and edges
  output logic      raw_level,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  localparam int CW = $clog2(FILTER_CYCLES + 1);

  logic          sync1;
  logic          stable;
  logic [CW-1:0] count;
  wire logic     differs = raw_level != stable;
  wire logic     settled = count == CW'(FILTER_CYCLES - 1);
  wire logic     chosen  = filter_en ? stable : raw_level;

  // Two-stage synchroniser; idles high like a pulled-up pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1     <= 1'b1;
      raw_level <= 1'b1;
    end else begin
      sync1     <= pin_in;
      raw_level <= sync1;
    end
  end

  // Filter: a new level must hold for the full count before it is accepted
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stable <= 1'b1;
      count  <= '0;
    end else begin
      count  <= (differs && !settled) ? count + CW'(1) : '0;
      stable <= (differs && settled) ? raw_level : stable;
    end
  end

  // Edges come from consecutive conditioned samples
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level <= 1'b1;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end else begin
      level <= chosen;
      rise  <= chosen && !level;
      fall  <= !chosen && level;
    end
  end

  bypass_path_a: assert property (@(posedge clk) disable iff (rst)
    !filter_en && !$past(filter_en) |-> level == $past(raw_level))
    else $error("unfiltered level does not follow the pin");
  filter_hold_a: assert property (@(posedge clk) disable iff (rst)
    filter_en && $past(filter_en) && $changed(stable) |-> $past(count) == CW'(FILTER_CYCLES - 1))
    else $error("filter accepted a level too early");
endmodule
`default_nettype wire

// ---- verilog/pin_driver.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_driver
  import gpio_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Output configuration
  input  wire logic       out_en,
  input  wire logic [3:0] out_sel,
  // Status flags
  input  wire logic       memory_busy_flag,
  input  wire logic       channel0_busy,
  input  wire logic       channel1_busy,
  input  wire logic       channel0_window_result,
  input  wire logic       channel1_window_result,
  // Pin drive
  output logic            pin_out,
  output logic            pin_oe_n
);
  logic picked;

  // Codes outside the table drive low rather than a stale flag
  always_comb begin
    unique case (out_sel)
      SEL_MEM_BUSY: picked = memory_busy_flag;
      SEL_CH1_BUSY: picked = channel1_busy;
      SEL_CH0_BUSY: picked = channel0_busy;
      SEL_CH1_WIN:  picked = channel1_window_result;
      SEL_CH0_WIN:  picked = channel0_window_result;
      default:      picked = 1'b0;
    endcase
  end

  // Pin is driven only while output mode is on
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_out  <= 1'b0;
      pin_oe_n <= 1'b1;
    end else begin
      pin_out  <= picked;
      pin_oe_n <= !out_en;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/multifunction_gpio_control.sv ----
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module multifunction_gpio_control
  import gpio_pkg::*;
#(
  parameter int FILTER_CYCLES = FILTER_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  // Multifunction pin
  input  wire logic              pin_in,
  output logic                   pin_out,
  output logic                   pin_oe_n,
  // Status flags for output mode
  input  wire logic              memory_busy_flag,
  input  wire logic              channel0_busy,
  input  wire logic              channel1_busy,
  input  wire logic              channel0_window_result,
  input  wire logic              channel1_window_result,
  // Stored pin configuration
  input  wire logic              nvm_config_stored,
  input  wire logic [DATA_W-1:0] nvm_pin_config,
  // Global actions
  output logic                   fault_dump_pulse,
  output logic                   protect_pulse,
  output logic      [1:0]        protect_action,
  output logic                   output_clear_action,
  output logic                   device_reset_hold,
  output logic                   nvm_write_allow,
  output logic                   register_lock,
  output logic                   low_power_select,
  // Channel actions, bit 0 channel 0, bit 1 channel 1
  output logic      [1:0]        current_output_down,
  output logic      [1:0]        current_output_up,
  output logic      [1:0]        voltage_output_down,
  output logic      [1:0]        voltage_output_up,
  output logic      [1:0]        load_output_strobe,
  output logic      [1:0]        wave_stop,
  output logic      [1:0]        wave_start,
  output logic      [1:0]        margin_low,
  output logic      [1:0]        margin_high
);
  // Channel enables from the channel select field
  function automatic logic [1:0] chan_enables(input logic [DATA_W-1:0] cfg);
    return {cfg[CH_SEL_LSB+CH1_SEL_BIT], cfg[CH_SEL_LSB+CH0_SEL_BIT]};
  endfunction

  logic [DATA_W-1:0] pin_function_config;
  logic [DATA_W-1:0] device_mode_settings;
  logic              raw_level;
  logic              pin_level;
  logic              pin_rise;
  logic              pin_fall;

  // Input conditioning: synchroniser, optional filter, edge pulses
  pin_conditioner #(
    .FILTER_CYCLES (FILTER_CYCLES)
  ) u_cond (
    .clk       (clk),
    .rst       (rst),
    .pin_in    (pin_in),
    .filter_en (pin_function_config[FILT_EN_BIT]),
    .raw_level (raw_level),
    .level     (pin_level),
    .rise      (pin_rise),
    .fall      (pin_fall)
  );

  // Output stage: selected status flag onto the pin
  pin_driver u_drv (
    .clk                    (clk),
    .rst                    (rst),
    .out_en                 (pin_function_config[OUT_EN_BIT]),
    .out_sel                (pin_function_config[OUT_SEL_LSB+:4]),
    .memory_busy_flag       (memory_busy_flag),
    .channel0_busy          (channel0_busy),
    .channel1_busy          (channel1_busy),
    .channel0_window_result (channel0_window_result),
    .channel1_window_result (channel1_window_result),
    .pin_out                (pin_out),
    .pin_oe_n               (pin_oe_n)
  );

  // Function decode: one-hot over codes, empty while input mode is off
  wire logic [3:0]  fn_code = pin_function_config[IN_FUNC_LSB+:4];
  wire logic        in_en   = pin_function_config[IN_EN_BIT];
  wire logic [15:0] fn_hit  = in_en ? (16'h0001 << fn_code) : 16'h0000;
  wire logic [1:0]  chan    = chan_enables(pin_function_config);
  wire logic [1:0]  ch_fall = chan & {2{pin_fall}};
  wire logic [1:0]  ch_rise = chan & {2{pin_rise}};

  // Next values of the action outputs
  wire logic       next_fault     = pin_fall && fn_hit[FN_FAULT_DUMP];
  wire logic       next_protect   = pin_fall && fn_hit[FN_PROTECT];
  wire logic       next_clear     = !pin_level && fn_hit[FN_CLEAR];
  wire logic [1:0] next_cur_down  = ch_fall & {2{fn_hit[FN_CUR_PWR]}};
  wire logic [1:0] next_cur_up    = ch_rise & {2{fn_hit[FN_CUR_PWR]}};
  wire logic [1:0] next_volt_down = ch_fall & {2{fn_hit[FN_VOLT_PWR]}};
  wire logic [1:0] next_volt_up   = ch_rise & {2{fn_hit[FN_VOLT_PWR]}};
  wire logic [1:0] next_load      = ch_fall & {2{fn_hit[FN_LOAD]}};
  wire logic [1:0] next_wave_stop = ch_fall & {2{fn_hit[FN_WAVE]}};
  wire logic [1:0] next_wave_go   = ch_rise & {2{fn_hit[FN_WAVE]}};
  wire logic [1:0] next_mar_low   = ch_fall & {2{fn_hit[FN_MARGIN]}};
  wire logic [1:0] next_mar_high  = ch_rise & {2{fn_hit[FN_MARGIN]}};

  // Level-type controls: falling edge sets reset hold and NVM write allow, rising edge clears; register lock is the reverse
  wire logic reset_enter   = pin_fall && fn_hit[FN_RESET];
  wire logic reset_release = pin_rise && fn_hit[FN_RESET] && device_reset_hold;
  wire logic next_reset    = reset_enter || (device_reset_hold && !reset_release);
  wire logic nvm_open      = pin_fall && fn_hit[FN_NVM_WP];
  wire logic nvm_shut      = pin_rise && fn_hit[FN_NVM_WP];
  wire logic next_nvm      = nvm_open || (nvm_write_allow && !nvm_shut);
  wire logic lock_open     = pin_fall && fn_hit[FN_REG_LOCK];
  wire logic lock_shut     = pin_rise && fn_hit[FN_REG_LOCK];
  wire logic next_lock     = lock_shut || (register_lock && !lock_open);

  // Register writes; a lock blocks both registers of this block
  wire logic              wr_ok     = wr && !register_lock;
  wire logic              wr_pin    = wr_ok && addr == PIN_CFG_ADDR;
  wire logic              wr_mode   = wr_ok && addr == MODE_CFG_ADDR;
  wire logic [DATA_W-1:0] reload    = nvm_config_stored ? nvm_pin_config : PIN_CFG_RESET;
  wire logic [DATA_W-1:0] next_pcfg = reset_release ? reload
                                    : wr_pin ? (wdata & PIN_CFG_MASK)
                                    : pin_function_config;
  wire logic [DATA_W-1:0] next_mode = reset_release ? MODE_CFG_RESET
                                    : wr_mode ? wdata : device_mode_settings;

  // Own status: pin levels and the held controls
  wire logic [DATA_W-1:0] status_word = DATA_W'({output_clear_action, register_lock,
                                                 nvm_write_allow, device_reset_hold,
                                                 pin_level, raw_level});

  // Read decode; unmapped addresses read as zero
  wire logic [DATA_W-1:0] read_mux =
      (addr == PIN_CFG_ADDR)    ? pin_function_config :
      (addr == MODE_CFG_ADDR)   ? device_mode_settings :
      (addr == PIN_STATUS_ADDR) ? status_word : '0;

  // Configuration registers; a pin-driven reset release reloads them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_function_config  <= PIN_CFG_RESET;
      device_mode_settings <= MODE_CFG_RESET;
    end else begin
      pin_function_config  <= next_pcfg;
      device_mode_settings <= next_mode;
    end
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else begin
      rdata <= rd ? read_mux : '0;
    end
  end

  // Global action outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_dump_pulse    <= 1'b0;
      protect_pulse       <= 1'b0;
      protect_action      <= 2'h0;
      output_clear_action <= 1'b0;
      device_reset_hold   <= 1'b0;
      nvm_write_allow     <= 1'b0;
      register_lock       <= 1'b0;
      low_power_select    <= 1'b0;
    end else begin
      fault_dump_pulse    <= next_fault;
      protect_pulse       <= next_protect;
      if (next_protect) begin
        protect_action <= device_mode_settings[PROT_ACT_LSB+:2];
      end
      output_clear_action <= next_clear;
      device_reset_hold   <= next_reset;
      nvm_write_allow     <= next_nvm;
      register_lock       <= next_lock;
      low_power_select    <= device_mode_settings[LOW_POWER_BIT];
    end
  end

  // Channel action pulses
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      current_output_down <= 2'h0;
      current_output_up   <= 2'h0;
      voltage_output_down <= 2'h0;
      voltage_output_up   <= 2'h0;
      load_output_strobe  <= 2'h0;
      wave_stop           <= 2'h0;
      wave_start          <= 2'h0;
      margin_low          <= 2'h0;
      margin_high         <= 2'h0;
    end else begin
      current_output_down <= next_cur_down;
      current_output_up   <= next_cur_up;
      voltage_output_down <= next_volt_down;
      voltage_output_up   <= next_volt_up;
      load_output_strobe  <= next_load;
      wave_stop           <= next_wave_stop;
      wave_start          <= next_wave_go;
      margin_low          <= next_mar_low;
      margin_high         <= next_mar_high;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Helper: any pulse action or clear, for the input-disable check
  wire logic any_action = fault_dump_pulse || protect_pulse || output_clear_action ||
                          (|current_output_down) || (|current_output_up) ||
                          (|voltage_output_down) || (|voltage_output_up) ||
                          (|load_output_strobe) || (|wave_stop) || (|wave_start) ||
                          (|margin_low) || (|margin_high);

  pin_drive_a: assert property (
    $past(pin_function_config[OUT_EN_BIT]) == !pin_oe_n)
    else $error("pin drive does not follow output enable");
  mem_busy_route_a: assert property (
    $past(pin_function_config[OUT_SEL_LSB+:4]) == SEL_MEM_BUSY |-> pin_out == $past(memory_busy_flag))
    else $error("pin does not show memory busy");
  chan_gate_a: assert property (
    (current_output_down & ~$past(chan)) == 2'h0 && (load_output_strobe & ~$past(chan)) == 2'h0)
    else $error("action on a channel that is not selected");
  fault_edge_a: assert property (
    fault_dump_pulse |-> !$past(pin_level) && $past(pin_level, 2) && $past(fn_code) == FN_FAULT_DUMP)
    else $error("fault dump without falling edge");
  cur_up_a: assert property (
    |current_output_up |-> $past(pin_level) && !$past(pin_level, 2))
    else $error("current power up without rising edge");
  volt_down_a: assert property (
    |voltage_output_down |-> !$past(pin_level) && $past(fn_code) == FN_VOLT_PWR)
    else $error("voltage power down without falling edge");
  protect_act_a: assert property (
    protect_pulse |-> protect_action == $past(device_mode_settings[PROT_ACT_LSB+:2])
                      && $past(pin_fall))
    else $error("protect response not captured at the edge");
  clear_level_a: assert property (
    in_en && fn_code == FN_CLEAR && !pin_level |=> output_clear_action)
    else $error("clear not held while pin low");
  load_edge_a: assert property (
    |load_output_strobe |-> $past(pin_fall) && $past(fn_code) == FN_LOAD)
    else $error("load strobe without falling edge");
  wave_start_a: assert property (
    |wave_start |-> $past(pin_rise) && !(|wave_stop))
    else $error("waveform start without rising edge");
  margin_pair_a: assert property (
    |margin_high |-> $past(pin_rise) && $past(fn_code) == FN_MARGIN)
    else $error("margin high without rising edge");
  reset_hold_a: assert property (
    $rose(device_reset_hold) |-> $past(pin_fall) && $past(fn_code) == FN_RESET)
    else $error("device reset without falling edge");
  config_reload_a: assert property (
    $fell(device_reset_hold) |-> pin_function_config == $past(reload))
    else $error("pin configuration not reloaded on release");
  nvm_allow_a: assert property (
    in_en && fn_code == FN_NVM_WP && pin_rise |=> !nvm_write_allow)
    else $error("memory programming not blocked");
  lock_write_a: assert property (
    $past(register_lock) && $past(wr) && !$fell(device_reset_hold) |-> $stable(pin_function_config))
    else $error("write passed while registers locked");
  input_off_a: assert property (
    !$past(in_en) |-> !any_action)
    else $error("action while input mode disabled");
  single_pulse_a: assert property (
    fault_dump_pulse |=> !fault_dump_pulse)
    else $error("action pulse longer than one cycle");
  invalid_code_a: assert property (
    $past(in_en) && $past(fn_code) == 4'h6 |-> !any_action && $stable(device_reset_hold))
    else $error("invalid code produced an action");

  // Edge and level checks for the remaining actions
  cur_down_a: assert property (
    |current_output_down |-> $past(pin_fall) && $past(fn_code) == FN_CUR_PWR)
    else $error("current power down without falling edge");
  volt_up_a: assert property (
    |voltage_output_up |-> $past(pin_rise) && $past(fn_code) == FN_VOLT_PWR)
    else $error("voltage power up without rising edge");
  protect_code_a: assert property (
    protect_pulse |-> $past(in_en) && $past(fn_code) == FN_PROTECT)
    else $error("protect fired under another function");
  clear_low_a: assert property (
    output_clear_action |-> !$past(pin_level) && $past(fn_code) == FN_CLEAR)
    else $error("clear asserted while pin high");
  wave_stop_a: assert property (
    |wave_stop |-> $past(pin_fall) && $past(fn_code) == FN_WAVE)
    else $error("waveform stop without falling edge");
  margin_low_a: assert property (
    |margin_low |-> $past(pin_fall) && $past(fn_code) == FN_MARGIN)
    else $error("margin low without falling edge");
  reset_release_a: assert property (
    $fell(device_reset_hold) |-> $past(pin_rise) && $past(fn_code) == FN_RESET)
    else $error("device reset released without rising edge");
  mode_reload_a: assert property (
    $fell(device_reset_hold) |-> device_mode_settings == MODE_CFG_RESET)
    else $error("mode settings kept across reset");
  nvm_open_a: assert property (
    in_en && fn_code == FN_NVM_WP && pin_fall |=> nvm_write_allow)
    else $error("memory programming not allowed");
  lock_set_a: assert property (
    in_en && fn_code == FN_REG_LOCK && pin_rise |=> register_lock)
    else $error("register lock not set on rising edge");

  protect_seen_c: cover property (protect_pulse);
  reset_cycle_c:  cover property ($rose(device_reset_hold) ##[1:40] $fell(device_reset_hold));
  both_chan_c:    cover property (load_output_strobe == 2'h3);
  pin_driven_c:   cover property (!pin_oe_n && pin_out);
endmodule
`default_nettype wire

// ---- test/pin_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_host (
  // Host request
  input  wire logic host_level,
  // Device drive
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  // Resolved pin
  output logic      pin_in
);
  // Host backs off while the device drives, so the wire never sees contention
  assign pin_in = pin_oe_n ? host_level : pin_out;
endmodule
`default_nettype wire

// ---- test/multifunction_gpio_control_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module multifunction_gpio_control_test
  import gpio_pkg::*;
;
  localparam int FC = 2;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wdata = 16'h0000;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic              host_level = 1'b1;
  logic              nvm_stored = 1'b1;
  logic [4:0]        flags = 5'h00;
  logic [DATA_W-1:0] rdata;
  logic              pin_in, pin_out, pin_oe_n, fault, prot, clear, rsth, nvm, lock, lowp;
  logic [1:0]        pact, cd, cu, vd, vu, ld, ws, wst, ml, mh;
  logic [23:0]       act;
  int                err_count = 0;
  int                num_checks = 0;
  int                cycles = 0;

  // Clock and a cycle ceiling that cuts a hang short
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end
  // Action outputs other than protect_action and low_power_select, packed into one vector for comparison
  assign act = {fault, prot, clear, rsth, nvm, lock, cd, cu, vd, vu, ld, ws, wst, ml, mh};

  multifunction_gpio_control #(.FILTER_CYCLES(FC)) u_dut (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .memory_busy_flag(flags[0]), .channel1_busy(flags[1]), .channel0_busy(flags[2]),
    .channel1_window_result(flags[3]), .channel0_window_result(flags[4]),
    .nvm_config_stored(nvm_stored), .nvm_pin_config(16'h0137),
    .fault_dump_pulse(fault), .protect_pulse(prot), .protect_action(pact),
    .output_clear_action(clear), .device_reset_hold(rsth), .nvm_write_allow(nvm),
    .register_lock(lock), .low_power_select(lowp), .current_output_down(cd),
    .current_output_up(cu), .voltage_output_down(vd), .voltage_output_up(vu),
    .load_output_strobe(ld), .wave_stop(ws), .wave_start(wst), .margin_low(ml),
    .margin_high(mh));
  pin_host u_host (.host_level(host_level), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_in(pin_in));

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rd_check(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk) {addr, rd} <= {a, 1'b1};
    @(posedge clk) rd <= 1'b0;
    #1 check(rdata, exp);
  endtask
  // Expected actions for one pin edge; m is {channel 1, channel 0}
  function automatic logic [23:0] expv(logic [3:0] c, logic [1:0] m, logic f, logic en);
    logic [23:0] v;
    v = 24'h000000;
    if (en) case (c)
      FN_FAULT_DUMP: v[23] = f;
      FN_PROTECT:    v[22] = f;
      FN_CLEAR:      v[21] = f;
      FN_RESET:      v[20] = f;
      FN_NVM_WP:     v[19] = f;
      FN_REG_LOCK:   v[18] = !f;
      FN_CUR_PWR:    v[17:14] = f ? {m, 2'h0} : {2'h0, m};
      FN_VOLT_PWR:   v[13:10] = f ? {m, 2'h0} : {2'h0, m};
      FN_LOAD:       v[9:8] = f ? m : 2'h0;
      FN_WAVE:       v[7:4] = f ? {m, 2'h0} : {2'h0, m};
      FN_MARGIN:     v[3:0] = f ? {m, 2'h0} : {2'h0, m};
      default:       v = 24'h000000;
    endcase
    return v;
  endfunction
  // One low pulse on the pin, judged a fixed latency after each edge
  task automatic pin_step(input logic [3:0] c, input logic [3:0] s, input logic en,
                          input logic flt);
    int d;
    d = flt ? 4 + FC : 4;
    wr_reg(PIN_CFG_ADDR, {flt, 6'h00, s, c, en});
    @(posedge clk) host_level <= 1'b0;
    repeat (d) @(posedge clk);
    #1 check(act, expv(c, {s[0], s[3]}, 1'b1, en));
    if (en && c == FN_PROTECT) check({22'h0, pact}, 24'h2);
    @(posedge clk) host_level <= 1'b1;
    repeat (d) @(posedge clk);
    #1 check(act, expv(c, {s[0], s[3]}, 1'b0, en));
  endtask

  task automatic test_regs;
    rd_check(PIN_CFG_ADDR, PIN_CFG_RESET);
    rd_check(MODE_CFG_ADDR, MODE_CFG_RESET);
    wr_reg(PIN_CFG_ADDR, 16'hffff);
    rd_check(PIN_CFG_ADDR, 16'hbfff);
    wr_reg(PIN_CFG_ADDR, 16'h0000);
    wr_reg(MODE_CFG_ADDR, 16'h2200);
    rd_check(MODE_CFG_ADDR, 16'h2200);
    check({23'h0, lowp}, 24'h1);
    rd_check(8'h10, 16'h0000);
    wr_reg(PIN_STATUS_ADDR, 16'hffff);
    rd_check(PIN_STATUS_ADDR, 16'h0003);
    $display("test regs done");
  endtask
  task automatic test_output;
    logic [3:0] sel [5];
    sel = '{SEL_MEM_BUSY, SEL_CH1_BUSY, SEL_CH0_BUSY, SEL_CH1_WIN, SEL_CH0_WIN};
    for (int i = 0; i < 5; i++) begin
      wr_reg(PIN_CFG_ADDR, {3'h1, sel[i], 9'h000});
      @(posedge clk) flags <= 5'h01 << i;
      repeat (3) @(posedge clk);
      #1 check({22'h0, pin_oe_n, pin_out}, 24'h1);
      @(posedge clk) flags <= ~(5'h01 << i);
      repeat (3) @(posedge clk);
      #1 check({22'h0, pin_oe_n, pin_out}, 24'h0);
    end
    wr_reg(PIN_CFG_ADDR, 16'h0000);
    repeat (4) @(posedge clk);
    #1 check({22'h0, pin_oe_n, pin_in}, 24'h3);
    $display("test output done");
  endtask
  task automatic test_input;
    logic [3:0] fn [10];
    fn = '{FN_FAULT_DUMP, FN_CUR_PWR, FN_VOLT_PWR, FN_PROTECT, FN_CLEAR, FN_LOAD,
           FN_WAVE, FN_MARGIN, FN_NVM_WP, 4'h6};
    foreach (fn[i]) pin_step(fn[i], 4'h9, 1'b1, 1'b0);
    pin_step(FN_LOAD, 4'h1, 1'b1, 1'b0);
    pin_step(FN_WAVE, 4'h8, 1'b1, 1'b0);
    pin_step(FN_FAULT_DUMP, 4'h9, 1'b0, 1'b0);
    pin_step(FN_FAULT_DUMP, 4'h9, 1'b1, 1'b1);
    pin_step(FN_RESET, 4'h9, 1'b1, 1'b0);
    rd_check(PIN_CFG_ADDR, 16'h0137);
    rd_check(MODE_CFG_ADDR, 16'h0000);
    // Without a stored copy the pin setup is lost across the reset
    @(posedge clk) nvm_stored <= 1'b0;
    pin_step(FN_RESET, 4'h9, 1'b1, 1'b0);
    rd_check(PIN_CFG_ADDR, 16'h0000);
    pin_step(FN_REG_LOCK, 4'h9, 1'b1, 1'b0);
    wr_reg(PIN_CFG_ADDR, 16'h0000);
    rd_check(PIN_CFG_ADDR, 16'h013b);
    $display("test input done");
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Reset for 20 cycles, then the scenarios in turn
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    test_regs();
    test_output();
    test_input();
    complete_run();
  end
endmodule
`default_nettype wire
